// ### verilog/tla_pkg.sv
package tla_pkg;

	localparam int ADDR_W = 10;
	localparam int DATA_W = 8;
	localparam int CODE_W = 11;

	// Register offsets within the register page
	localparam logic [9:0] OFS_LOW_THRESHOLD = 10'h208;
	localparam logic [9:0] OFS_HIGH_THRESHOLD = 10'h209;
	localparam logic [9:0] OFS_RESULT_LOW = 10'h20c;
	localparam logic [9:0] OFS_RESULT_HIGH = 10'h20d;
	localparam logic [9:0] OFS_ALARM_ENABLE = 10'h210;
	localparam logic [9:0] OFS_CLOCK_CONTROL = 10'h212;
	localparam logic [9:0] OFS_MISSION_CONTROL = 10'h213;
	localparam logic [9:0] OFS_ALARM_STATUS = 10'h214;

	// Field positions
	localparam int BIT_LOW_ALARM_ENABLE = 0;
	localparam int BIT_HIGH_ALARM_ENABLE = 1;
	localparam int BIT_OSCILLATOR_RUN = 0;
	localparam int BIT_SECONDS_TIME_BASE = 1;
	localparam int BIT_LOGGING_ENABLE = 0;
	localparam int BIT_LOG_FORMAT_SELECT = 2;
	localparam int BIT_WRAP_ON_FULL = 4;
	localparam int BIT_ALARM_TRIGGERED_START = 5;
	localparam int BIT_LOW_ALARM_FLAG = 0;
	localparam int BIT_HIGH_ALARM_FLAG = 1;

	// Fixed bits and reset values
	localparam logic [7:0] MISSION_FIXED_ONES = 8'hc0;
	localparam logic [7:0] STATUS_FIXED_ONES = 8'h70;
	localparam logic [7:0] RESET_THRESHOLD = 8'h00;
	localparam logic [7:0] RESET_RESULT = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// Out-of-range result codes and the 8-bit mode low byte
	localparam logic [7:0] RANGE_LOW_HIGH_BYTE = 8'h00;
	localparam logic [7:0] RANGE_LOW_LOW_BYTE = 8'h00;
	localparam logic [7:0] RANGE_HIGH_HIGH_BYTE = 8'hff;
	localparam logic [7:0] RANGE_HIGH_LOW_BYTE_16 = 8'he0;
	localparam logic [7:0] RANGE_HIGH_LOW_BYTE_8 = 8'h00;
	localparam logic [7:0] LOW_BYTE_8BIT_MODE = 8'h00;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} tla_reg_req_t;

	typedef struct packed {
		logic valid;
		logic under_range;
		logic over_range;
		logic [CODE_W-1:0] code;
	} tla_conv_t;

endpackage : tla_pkg

// ### verilog/tla_regs.sv
// Summary of operation
// RULE_01: Latest result shown as high byte bits 10..3, low byte bits 2..0 on top.
// RULE_02: Result encoding is half degrees plus fraction, minus variant offset; carried unchanged.
// RULE_03: Alarm compares use only the result high byte, in either format.
// RULE_04: Two one-byte thresholds, low and high, in result high-byte encoding.
// RULE_05: An alarm is raised only when value alarms and its enable is set.
// RULE_06: In a mission, low enable and result at or below low threshold sets low flag.
// RULE_07: In a mission, high enable and result at or above high threshold sets high flag.
// RULE_08: Alarm enable register keeps bits 0 and 1; bits 2..7 read zero.
// RULE_09: Enable, clock and mission control registers ignore writes during a mission.
// RULE_10: Clock control register keeps bits 0 and 1; bits 2..7 read zero.
// RULE_11: Oscillator run bit starts the oscillator at 1, stops it at 0.
// RULE_12: Host never requests a conversion while the oscillator is stopped.
// RULE_13: Time base bit selects minutes at 0 and seconds at 1.
// RULE_14: Host should stop the oscillator while the logger is idle.
// RULE_15: Mission control fields at bits 5,4,2,0; bits 7 and 6 always read one.
// RULE_16: Host writes zero to mission bit 1; bit 3 then has no effect.
// RULE_17: In 16-bit mode low byte has five zero bits; 8-bit mode low byte undefined.
// RULE_18: Format bit picks 8-bit storage at 0, 16-bit at 1, high byte first.
// RULE_19: Under range reads all zeros; over range reads FFh or FFE0h.
// RULE_20: Alarm flags at status bits 0 and 1, cleared together by clear-memory.
// RULE_21: A set flag stays set until cleared; evaluated once per finished conversion.
module tla_regs
	import tla_pkg::*;
(
	input wire logic ref_clk,
	input wire logic srst,
	input wire tla_reg_req_t reg_req,
	output logic [DATA_W-1:0] rd_data,
	output logic rd_valid,
	input wire tla_conv_t conv,
	input wire logic mission_active,
	input wire logic clear_alarms,
	output logic low_alarm_flag,
	output logic high_alarm_flag,
	output logic oscillator_run,
	output logic seconds_time_base,
	output logic log_format_select,
	output logic wrap_on_full,
	output logic alarm_triggered_start,
	output logic logging_enable,
	output logic [DATA_W-1:0] result_high_byte,
	output logic [DATA_W-1:0] result_low_byte
);

	logic [DATA_W-1:0] low_alarm_threshold_reg;
	logic [DATA_W-1:0] high_alarm_threshold_reg;
	logic low_alarm_enable_reg;
	logic high_alarm_enable_reg;
	logic [DATA_W-1:0] result_high_next;
	logic [DATA_W-1:0] result_low_next;
	logic low_hit;
	logic high_hit;
	logic cfg_write_ok;

	// Alarm enable, clock control and mission control writes are locked out while a mission runs
	assign cfg_write_ok = reg_req.wr_en && !mission_active; // RULE_09

	// Result byte formation, including out-of-range codes
	always_comb begin
		result_high_next = conv.code[CODE_W-1:3]; // RULE_01
		if (log_format_select) begin
			result_low_next = {conv.code[2:0], 5'h00}; // RULE_01 RULE_17
		end else begin
			result_low_next = LOW_BYTE_8BIT_MODE; // RULE_17
		end
		if (conv.under_range) begin
			result_high_next = RANGE_LOW_HIGH_BYTE; // RULE_19
			result_low_next = RANGE_LOW_LOW_BYTE; // RULE_19
		end else if (conv.over_range) begin
			result_high_next = RANGE_HIGH_HIGH_BYTE; // RULE_19
			if (log_format_select) begin
				result_low_next = RANGE_HIGH_LOW_BYTE_16; // RULE_19
			end else begin
				result_low_next = RANGE_HIGH_LOW_BYTE_8; // RULE_19
			end
		end
	end

	// Only the high byte takes part in the compare, in either format
	always_comb begin
		low_hit = conv.valid && mission_active && low_alarm_enable_reg &&
			(result_high_next <= low_alarm_threshold_reg); // RULE_03 RULE_05 RULE_06
		high_hit = conv.valid && mission_active && high_alarm_enable_reg &&
			(result_high_next >= high_alarm_threshold_reg); // RULE_03 RULE_05 RULE_07
	end

	// Latest result registers; the code is carried in its native encoding
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			result_high_byte <= RESET_RESULT;
			result_low_byte <= RESET_RESULT;
		end else if (conv.valid) begin
			result_high_byte <= result_high_next; // RULE_01 RULE_02
			result_low_byte <= result_low_next; // RULE_01 RULE_02
		end
	end

	// Thresholds stay writable; they only steer the compare
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			low_alarm_threshold_reg <= RESET_THRESHOLD;
			high_alarm_threshold_reg <= RESET_THRESHOLD;
		end else if (reg_req.wr_en) begin
			if (reg_req.addr == OFS_LOW_THRESHOLD) begin
				low_alarm_threshold_reg <= reg_req.wdata; // RULE_04
			end
			if (reg_req.addr == OFS_HIGH_THRESHOLD) begin
				high_alarm_threshold_reg <= reg_req.wdata; // RULE_04
			end
		end
	end

	// Alarm enables: upper bits are not stored at all
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			low_alarm_enable_reg <= 1'b0;
			high_alarm_enable_reg <= 1'b0;
		end else if (cfg_write_ok && reg_req.addr == OFS_ALARM_ENABLE) begin
			low_alarm_enable_reg <= reg_req.wdata[BIT_LOW_ALARM_ENABLE]; // RULE_08
			high_alarm_enable_reg <= reg_req.wdata[BIT_HIGH_ALARM_ENABLE]; // RULE_08
		end
	end

	// Clock control; reset leaves the oscillator stopped to save power
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			oscillator_run <= 1'b0;
			seconds_time_base <= 1'b0;
		end else if (cfg_write_ok && reg_req.addr == OFS_CLOCK_CONTROL) begin
			oscillator_run <= reg_req.wdata[BIT_OSCILLATOR_RUN]; // RULE_10 RULE_11
			seconds_time_base <= reg_req.wdata[BIT_SECONDS_TIME_BASE]; // RULE_10 RULE_13
		end
	end

	// Mission control; bits 1 and 3 have no storage, so bit 3 is ignored
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			logging_enable <= 1'b0;
			log_format_select <= 1'b0;
			wrap_on_full <= 1'b0;
			alarm_triggered_start <= 1'b0;
		end else if (cfg_write_ok && reg_req.addr == OFS_MISSION_CONTROL) begin
			logging_enable <= reg_req.wdata[BIT_LOGGING_ENABLE]; // RULE_15
			log_format_select <= reg_req.wdata[BIT_LOG_FORMAT_SELECT]; // RULE_15 RULE_18
			wrap_on_full <= reg_req.wdata[BIT_WRAP_ON_FULL]; // RULE_15
			alarm_triggered_start <= reg_req.wdata[BIT_ALARM_TRIGGERED_START]; // RULE_15
		end
	end

	// Sticky flags: a hit in the clearing cycle wins over the clear
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			low_alarm_flag <= 1'b0;
			high_alarm_flag <= 1'b0;
		end else begin
			if (low_hit) begin
				low_alarm_flag <= 1'b1; // RULE_06 RULE_21
			end else if (clear_alarms) begin
				low_alarm_flag <= 1'b0; // RULE_20
			end
			if (high_hit) begin
				high_alarm_flag <= 1'b1; // RULE_07 RULE_21
			end else if (clear_alarms) begin
				high_alarm_flag <= 1'b0; // RULE_20
			end
		end
	end

	// Read port: one-cycle latency, unmapped offsets read zero
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rd_valid <= 1'b0;
			rd_data <= UNMAPPED_READ;
		end else begin
			rd_valid <= reg_req.rd_en;
			if (reg_req.rd_en) begin
				case (reg_req.addr)
					OFS_LOW_THRESHOLD: begin
						rd_data <= low_alarm_threshold_reg;
					end
					OFS_HIGH_THRESHOLD: begin
						rd_data <= high_alarm_threshold_reg;
					end
					OFS_RESULT_LOW: begin
						rd_data <= result_low_byte; // RULE_01
					end
					OFS_RESULT_HIGH: begin
						rd_data <= result_high_byte; // RULE_01
					end
					OFS_ALARM_ENABLE: begin
						rd_data <= {6'h00, high_alarm_enable_reg, low_alarm_enable_reg}; // RULE_08
					end
					OFS_CLOCK_CONTROL: begin
						rd_data <= {6'h00, seconds_time_base, oscillator_run}; // RULE_10
					end
					OFS_MISSION_CONTROL: begin
						rd_data <= MISSION_FIXED_ONES |
							{2'h0, alarm_triggered_start, wrap_on_full, 1'b0,
							log_format_select, 1'b0, logging_enable}; // RULE_15 RULE_16
					end
					OFS_ALARM_STATUS: begin
						rd_data <= STATUS_FIXED_ONES |
							{6'h00, high_alarm_flag, low_alarm_flag}; // RULE_20
					end
					default: begin
						rd_data <= UNMAPPED_READ;
					end
				endcase
			end
		end
	end

	// Flags move only on a conversion inside a mission, or fall on a clear
	AST_LOW_SETS: assert property (@(posedge ref_clk) disable iff (srst) // RULE_06
		(conv.valid && mission_active && low_alarm_enable_reg &&
		result_high_next <= low_alarm_threshold_reg) |=> low_alarm_flag)
		else $error("Low alarm flag not set after alarming conversion");

	AST_HIGH_SETS: assert property (@(posedge ref_clk) disable iff (srst) // RULE_07
		(conv.valid && mission_active && high_alarm_enable_reg &&
		result_high_next >= high_alarm_threshold_reg) |=> high_alarm_flag)
		else $error("High alarm flag not set after alarming conversion");

	AST_LOW_GATED: assert property (@(posedge ref_clk) disable iff (srst) // RULE_05
		(!low_alarm_flag && !low_alarm_enable_reg) |=> !low_alarm_flag)
		else $error("Low alarm flag rose with its enable cleared");

	AST_HIGH_GATED: assert property (@(posedge ref_clk) disable iff (srst) // RULE_05
		(!high_alarm_flag && !high_alarm_enable_reg) |=> !high_alarm_flag)
		else $error("High alarm flag rose with its enable cleared");

	AST_LOW_IDLE: assert property (@(posedge ref_clk) disable iff (srst) // RULE_06
		(!low_alarm_flag && !mission_active) |=> !low_alarm_flag)
		else $error("Low alarm flag rose outside a mission");

	AST_HIGH_IDLE: assert property (@(posedge ref_clk) disable iff (srst) // RULE_07
		(!high_alarm_flag && !mission_active) |=> !high_alarm_flag)
		else $error("High alarm flag rose outside a mission");

	AST_STICKY: assert property (@(posedge ref_clk) disable iff (srst) // RULE_21
		(low_alarm_flag && !clear_alarms) |=> low_alarm_flag)
		else $error("Low alarm flag dropped without a clear");

	AST_HIGH_STICKY: assert property (@(posedge ref_clk) disable iff (srst) // RULE_21
		(high_alarm_flag && !clear_alarms) |=> high_alarm_flag)
		else $error("High alarm flag dropped without a clear");

	AST_LOW_ONCE: assert property (@(posedge ref_clk) disable iff (srst) // RULE_21
		(!low_alarm_flag && !conv.valid) |=> !low_alarm_flag)
		else $error("Low alarm flag rose without a conversion");

	AST_HIGH_ONCE: assert property (@(posedge ref_clk) disable iff (srst) // RULE_21
		(!high_alarm_flag && !conv.valid) |=> !high_alarm_flag)
		else $error("High alarm flag rose without a conversion");

	AST_CLEAR: assert property (@(posedge ref_clk) disable iff (srst) // RULE_20
		(clear_alarms && !conv.valid) |=> (!low_alarm_flag && !high_alarm_flag))
		else $error("Alarm flags not cleared together");

	// Lock checks look one edge back: a write taken while the mission flag
	// was still low may land on the first mission cycle
	AST_MISSION_LOCK: assert property (@(posedge ref_clk) disable iff (srst) // RULE_09
		mission_active |=> ($stable(oscillator_run) && $stable(logging_enable) &&
		$stable(low_alarm_enable_reg)))
		else $error("Locked register changed during a mission");

	AST_MISSION_LOCK_REST: assert property (@(posedge ref_clk) disable iff (srst) // RULE_09
		mission_active |=> ($stable(seconds_time_base) && $stable(log_format_select) &&
		$stable(wrap_on_full) && $stable(alarm_triggered_start) &&
		$stable(high_alarm_enable_reg)))
		else $error("Locked register field changed during a mission");

	AST_ENABLE_WRITE: assert property (@(posedge ref_clk) disable iff (srst) // RULE_08
		(reg_req.wr_en && !mission_active && reg_req.addr == OFS_ALARM_ENABLE) |=>
		({high_alarm_enable_reg, low_alarm_enable_reg} == $past(reg_req.wdata[1:0])))
		else $error("Alarm enable write not taken between missions");

	AST_CLOCK_WRITE: assert property (@(posedge ref_clk) disable iff (srst) // RULE_11 RULE_13
		(reg_req.wr_en && !mission_active && reg_req.addr == OFS_CLOCK_CONTROL) |=>
		({seconds_time_base, oscillator_run} == $past(reg_req.wdata[1:0])))
		else $error("Clock control write not taken between missions");

	AST_LOW_THRESHOLD_WRITE: assert property (@(posedge ref_clk) disable iff (srst) // RULE_04
		(reg_req.wr_en && reg_req.addr == OFS_LOW_THRESHOLD) |=>
		(low_alarm_threshold_reg == $past(reg_req.wdata)))
		else $error("Low threshold write not taken");

	AST_HIGH_THRESHOLD_WRITE: assert property (@(posedge ref_clk) disable iff (srst) // RULE_04
		(reg_req.wr_en && reg_req.addr == OFS_HIGH_THRESHOLD) |=>
		(high_alarm_threshold_reg == $past(reg_req.wdata)))
		else $error("High threshold write not taken");

	AST_RESULT_SPLIT: assert property (@(posedge ref_clk) disable iff (srst) // RULE_01
		(conv.valid && !conv.under_range && !conv.over_range) |=>
		(result_high_byte == $past(conv.code[10:3])))
		else $error("Result high byte does not hold code bits 10 to 3");

	AST_RESULT_LOW_16: assert property (@(posedge ref_clk) disable iff (srst) // RULE_17
		(conv.valid && !conv.under_range && !conv.over_range && log_format_select) |=>
		(result_low_byte == {$past(conv.code[2:0]), 5'h00}))
		else $error("Result low byte does not hold code bits 2 to 0 on top");

	AST_RESULT_HOLD: assert property (@(posedge ref_clk) disable iff (srst) // RULE_01
		!conv.valid |=> ($stable(result_high_byte) && $stable(result_low_byte)))
		else $error("Result bytes changed without a conversion");

	AST_LOW_ZEROS: assert property (@(posedge ref_clk) disable iff (srst) // RULE_17
		result_low_byte[4:0] == 5'h00)
		else $error("Result low byte has nonzero bits below bit 5");

	AST_UNDER_RANGE: assert property (@(posedge ref_clk) disable iff (srst) // RULE_19
		(conv.valid && conv.under_range) |=>
		(result_high_byte == 8'h00 && result_low_byte == 8'h00))
		else $error("Under-range result not reported as all zeros");

	AST_OVER_RANGE: assert property (@(posedge ref_clk) disable iff (srst) // RULE_19
		(conv.valid && conv.over_range && !conv.under_range) |=>
		(result_high_byte == 8'hff))
		else $error("Over-range result not reported as all ones");

	AST_OVER_RANGE_16: assert property (@(posedge ref_clk) disable iff (srst) // RULE_19
		(conv.valid && conv.over_range && !conv.under_range && log_format_select) |=>
		(result_low_byte == 8'he0))
		else $error("Over-range low byte wrong in 16-bit mode");

	AST_MISSION_READ: assert property (@(posedge ref_clk) disable iff (srst) // RULE_15
		(reg_req.rd_en && reg_req.addr == OFS_MISSION_CONTROL) |=>
		(rd_valid && rd_data[7:6] == 2'h3 && rd_data[3] == 1'b0))
		else $error("Mission control read lacks fixed bits");

	AST_ENABLE_READ: assert property (@(posedge ref_clk) disable iff (srst) // RULE_08
		(reg_req.rd_en && (reg_req.addr == OFS_ALARM_ENABLE ||
		reg_req.addr == OFS_CLOCK_CONTROL)) |=> (rd_data[7:2] == 6'h00))
		else $error("Unimplemented control bits read nonzero");

	AST_CLOCK_READ: assert property (@(posedge ref_clk) disable iff (srst) // RULE_10
		(reg_req.rd_en && reg_req.addr == OFS_CLOCK_CONTROL) |=>
		(rd_data[1:0] == $past({seconds_time_base, oscillator_run})))
		else $error("Clock control read does not show its bits");

	AST_STATUS_READ: assert property (@(posedge ref_clk) disable iff (srst) // RULE_20
		(reg_req.rd_en && reg_req.addr == OFS_ALARM_STATUS) |=>
		(rd_data[1:0] == $past({high_alarm_flag, low_alarm_flag}) && rd_data[6:4] == 3'h7))
		else $error("Alarm status read does not show the flags");

endmodule : tla_regs

// ### bench/tla_host.sv
module tla_host
	import tla_pkg::*;
(
	input wire logic ref_clk,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic rd_valid,
	output tla_reg_req_t reg_req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial reg_req = '0;

	// Between requests the bus shows inverted address and data, never a stale copy
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] v;
		v = (a == OFS_MISSION_CONTROL) ? (d & 8'hfd) : d;
		@(posedge ref_clk);
		reg_req <= '{1'b1, 1'b0, a, v};
		@(posedge ref_clk);
		reg_req <= '{1'b0, 1'b0, ~a, ~v};
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic ok);
		@(posedge ref_clk);
		reg_req <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge ref_clk);
		reg_req <= '{1'b0, 1'b0, ~a, 8'hff};
		@(negedge ref_clk);
		ok = rd_valid;
		d = rd_data;
	endtask : rd
endmodule : tla_host

// ### bench/temp_logger_alarm_control_regs_tb.sv
module temp_logger_alarm_control_regs_tb
	import tla_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	tla_reg_req_t reg_req;
	logic [DATA_W-1:0] rd_data, result_high_byte, result_low_byte;
	logic rd_valid, low_alarm_flag, high_alarm_flag, oscillator_run, seconds_time_base;
	logic log_format_select, wrap_on_full, alarm_triggered_start, logging_enable;
	tla_conv_t conv = '0;
	logic mission_active = 1'b0;
	logic clear_alarms = 1'b0;
	int err_total = 0;
	int n_checks = 0;
	int cyc = 0;

	always #12.5 ref_clk = ~ref_clk;

	tla_regs dut_u (.ref_clk(ref_clk), .srst(srst), .reg_req(reg_req), .rd_data(rd_data),
		.rd_valid(rd_valid), .conv(conv), .mission_active(mission_active),
		.clear_alarms(clear_alarms), .low_alarm_flag(low_alarm_flag),
		.high_alarm_flag(high_alarm_flag), .oscillator_run(oscillator_run),
		.seconds_time_base(seconds_time_base), .log_format_select(log_format_select),
		.wrap_on_full(wrap_on_full), .alarm_triggered_start(alarm_triggered_start),
		.logging_enable(logging_enable), .result_high_byte(result_high_byte),
		.result_low_byte(result_low_byte));

	tla_host host_u (.ref_clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid), .reg_req(reg_req));

	task automatic results();
		$display("Checks %0d, errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic ok;
		host_u.rd(a, d, ok);
		chk({7'h00, ok}, 8'h01);
		chk(d, exp);
	endtask : rchk

	// Conversions are only issued while the oscillator runs; the device cannot recover otherwise
	task automatic cv(input logic [CODE_W-1:0] c, input logic u, input logic o);
		if (oscillator_run === 1'b1) begin
			@(posedge ref_clk);
			conv <= '{1'b1, u, o, c};
			@(posedge ref_clk);
			conv <= '{1'b0, ~u, ~o, ~c};
			@(posedge ref_clk);
			@(negedge ref_clk);
		end
	endtask : cv

	task automatic flags(input logic [1:0] exp);
		chk({6'h00, high_alarm_flag, low_alarm_flag}, {6'h00, exp});
	endtask : flags

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			err_total++;
			results();
		end
	end

	initial begin
		repeat (12) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		rchk(OFS_LOW_THRESHOLD, RESET_THRESHOLD);
		rchk(OFS_ALARM_ENABLE, 8'h00);
		rchk(OFS_CLOCK_CONTROL, 8'h00);
		rchk(OFS_MISSION_CONTROL, 8'hc0);
		rchk(OFS_ALARM_STATUS, 8'h70);
		rchk(10'h215, 8'h00);
		host_u.wr(OFS_ALARM_ENABLE, 8'hff);
		rchk(OFS_ALARM_ENABLE, 8'h03);
		host_u.wr(OFS_CLOCK_CONTROL, 8'hfe);
		rchk(OFS_CLOCK_CONTROL, 8'h02);
		chk({6'h00, seconds_time_base, oscillator_run}, 8'h02);
		host_u.wr(OFS_CLOCK_CONTROL, 8'hfd);
		rchk(OFS_CLOCK_CONTROL, 8'h01);
		chk({6'h00, seconds_time_base, oscillator_run}, 8'h01);
		host_u.wr(OFS_MISSION_CONTROL, 8'h00);
		rchk(OFS_MISSION_CONTROL, 8'hc0);
		host_u.wr(OFS_MISSION_CONTROL, 8'h3d);
		rchk(OFS_MISSION_CONTROL, 8'hf5);
		chk({4'h0, alarm_triggered_start, wrap_on_full, log_format_select, logging_enable},
			8'h0f);
		cv(11'h2b5, 1'b0, 1'b0);
		rchk(OFS_RESULT_HIGH, 8'h56);
		rchk(OFS_RESULT_LOW, 8'ha0);
		cv(11'h3ff, 1'b1, 1'b0);
		chk(result_high_byte | result_low_byte, 8'h00);
		cv(11'h123, 1'b0, 1'b1);
		chk(result_high_byte & result_low_byte, 8'he0);
		host_u.wr(OFS_LOW_THRESHOLD, 8'h40);
		host_u.wr(OFS_HIGH_THRESHOLD, 8'h80);
		rchk(OFS_LOW_THRESHOLD, 8'h40);
		rchk(OFS_HIGH_THRESHOLD, 8'h80);
		cv({8'h40, 3'h7}, 1'b0, 1'b0);
		flags(2'b00);
		@(posedge ref_clk) mission_active <= 1'b1;
		host_u.wr(OFS_ALARM_ENABLE, 8'h00);
		host_u.wr(OFS_CLOCK_CONTROL, 8'h00);
		host_u.wr(OFS_MISSION_CONTROL, 8'h00);
		rchk(OFS_ALARM_ENABLE, 8'h03);
		rchk(OFS_CLOCK_CONTROL, 8'h01);
		rchk(OFS_MISSION_CONTROL, 8'hf5);
		cv({8'h41, 3'h0}, 1'b0, 1'b0);
		flags(2'b00);
		cv({8'h40, 3'h7}, 1'b0, 1'b0);
		flags(2'b01);
		cv({8'h7f, 3'h7}, 1'b0, 1'b0);
		flags(2'b01);
		cv({8'h80, 3'h0}, 1'b0, 1'b0);
		flags(2'b11);
		cv({8'h60, 3'h0}, 1'b0, 1'b0);
		flags(2'b11);
		rchk(OFS_ALARM_STATUS, 8'h73);
		@(posedge ref_clk) clear_alarms <= 1'b1;
		@(posedge ref_clk) clear_alarms <= 1'b0;
		@(negedge ref_clk);
		flags(2'b00);
		@(posedge ref_clk) mission_active <= 1'b0;
		host_u.wr(OFS_ALARM_ENABLE, 8'h00);
		@(posedge ref_clk) mission_active <= 1'b1;
		cv(11'h000, 1'b1, 1'b0);
		cv(11'h000, 1'b0, 1'b1);
		flags(2'b00);
		@(posedge ref_clk) mission_active <= 1'b0;
		host_u.wr(OFS_MISSION_CONTROL, 8'hc1);
		rchk(OFS_MISSION_CONTROL, 8'hc1);
		cv(11'h2b5, 1'b0, 1'b0);
		chk(result_high_byte, 8'h56);
		chk(result_low_byte, LOW_BYTE_8BIT_MODE);
		cv(11'h2b5, 1'b0, 1'b1);
		chk(result_high_byte, 8'hff);
		chk(result_low_byte, RANGE_HIGH_LOW_BYTE_8);
		host_u.wr(OFS_CLOCK_CONTROL, 8'h00);
		rchk(OFS_CLOCK_CONTROL, 8'h00);
		chk({7'h00, oscillator_run}, 8'h00);
		results();
	end
endmodule : temp_logger_alarm_control_regs_tb
